// ===== inc/chi_params.svh
`ifndef CHI_PARAMS_SVH
`define CHI_PARAMS_SVH

`define CHI_SLAVE_ADDR 7'h6B
`define CHI_MCODE_PREFIX 5'h01
`define CHI_NUM_REGS 3'h5
`define CHI_UNMAPPED_BYTE 8'hFF
`define CHI_LAST_BIT 3'h7
`define CHI_DIR_READ 1'b1

`endif

// ===== inc/chi_pkg.sv
package chi_pkg;

  typedef enum logic [9:0] {
    CHI_ST_IDLE      = 10'h001,
    CHI_ST_ADDR      = 10'h002,
    CHI_ST_ADDR_ACK  = 10'h004,
    CHI_ST_REG       = 10'h008,
    CHI_ST_REG_ACK   = 10'h010,
    CHI_ST_WDATA     = 10'h020,
    CHI_ST_WDATA_ACK = 10'h040,
    CHI_ST_RDATA     = 10'h080,
    CHI_ST_RDATA_ACK = 10'h100,
    CHI_ST_IGNORE    = 10'h200
  } chi_state_e;

endpackage

// ===== hw/chi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "chi_params.svh"

module chi_slave #(
  parameter logic [2:0] RO_REG = 3'h0
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic wr_en_o,
  output logic [2:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic [2:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic hs_mode_o,
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Register address decode
  // ----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a[7:3] == 5'h00) && (a[2:0] < `CHI_NUM_REGS);
  endfunction

  function automatic logic reg_writable(input logic [7:0] a);
    reg_writable = reg_mapped(a) && (a[2:0] != RO_REG);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_m_q;
  logic scl_s_q;
  logic scl_p_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_p_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Every sampled clock edge but the fall closing a start counts: a glitch on the clock line is taken
  // as a real bit, so the line must be clean.
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl_s_q && !scl_p_q;
  assign scl_fall = !scl_s_q && scl_p_q;
  assign start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
  assign stop_ev = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  chi_pkg::chi_state_e state_q;
  chi_pkg::chi_state_e state_d;
  logic [2:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic mack_q;
  logic hs_q;
  logic drv_q;
  logic drv_d;
  logic first_fall_q;
  logic byte_done;
  logic addr_hit;
  logic mcode;
  logic [7:0] rd_byte;

  assign byte_done = (cnt_q == `CHI_LAST_BIT);
  // High-speed reads are not offered, so a read address in that mode
  // is left unanswered.
  assign addr_hit = (shift_q[7:1] == `CHI_SLAVE_ADDR)
                    && !(shift_q[0] == `CHI_DIR_READ && hs_q);
  assign mcode = (shift_q[7:3] == `CHI_MCODE_PREFIX);
  assign rd_byte = reg_mapped(ptr_q) ? rd_data_i : `CHI_UNMAPPED_BYTE;

  always_comb begin
    state_d = state_q;
    drv_d = 1'b0;
    unique case (state_q)
      chi_pkg::CHI_ST_IDLE: begin
        state_d = chi_pkg::CHI_ST_IDLE;
      end
      chi_pkg::CHI_ST_ADDR: begin
        if (byte_done) begin
          if (addr_hit) begin
            state_d = chi_pkg::CHI_ST_ADDR_ACK;
            drv_d = 1'b1;
          end else begin
            state_d = chi_pkg::CHI_ST_IGNORE;
          end
        end
      end
      chi_pkg::CHI_ST_ADDR_ACK: begin
        if (rw_q == `CHI_DIR_READ) begin
          state_d = chi_pkg::CHI_ST_RDATA;
          drv_d = !rd_byte[7];
        end else begin
          state_d = chi_pkg::CHI_ST_REG;
        end
      end
      chi_pkg::CHI_ST_REG: begin
        if (byte_done) begin
          state_d = chi_pkg::CHI_ST_REG_ACK;
          drv_d = 1'b1;
        end
      end
      chi_pkg::CHI_ST_REG_ACK: begin
        state_d = chi_pkg::CHI_ST_WDATA;
      end
      chi_pkg::CHI_ST_WDATA: begin
        if (byte_done) begin
          state_d = chi_pkg::CHI_ST_WDATA_ACK;
          drv_d = 1'b1;
        end
      end
      chi_pkg::CHI_ST_WDATA_ACK: begin
        state_d = chi_pkg::CHI_ST_REG;
      end
      chi_pkg::CHI_ST_RDATA: begin
        if (byte_done) begin
          state_d = chi_pkg::CHI_ST_RDATA_ACK;
        end else begin
          drv_d = !tx_q[6];
        end
      end
      chi_pkg::CHI_ST_RDATA_ACK: begin
        if (mack_q) begin
          state_d = chi_pkg::CHI_ST_RDATA;
          drv_d = !rd_byte[7];
        end else begin
          state_d = chi_pkg::CHI_ST_IGNORE;
        end
      end
      chi_pkg::CHI_ST_IGNORE: begin
        state_d = chi_pkg::CHI_ST_IGNORE;
      end
      default: begin
        state_d = chi_pkg::CHI_ST_IDLE;
      end
    endcase
  end

  // The clock fall that closes a start condition ends no bit. Counting it
  // would make the address byte come out one bit short.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_fall_q <= 1'b0;
    end else if (start_ev) begin
      first_fall_q <= 1'b1;
    end else if (stop_ev || scl_fall) begin
      first_fall_q <= 1'b0;
    end
  end

  // Start wins over everything, so a repeated start always restarts
  // address decode even in the middle of a byte.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= chi_pkg::CHI_ST_IDLE;
      cnt_q <= 3'h0;
    end else if (start_ev) begin
      state_q <= chi_pkg::CHI_ST_ADDR;
      cnt_q <= 3'h0;
    end else if (stop_ev) begin
      state_q <= chi_pkg::CHI_ST_IDLE;
      cnt_q <= 3'h0;
    end else if (scl_fall && !first_fall_q) begin
      state_q <= state_d;
      if (state_d != state_q) begin
        cnt_q <= 3'h0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // Bits are taken on the rising clock edge only in receiving states, so
  // the device's own acknowledge never lands in the shift register.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= 8'h00;
    end else if (scl_rise && (state_q == chi_pkg::CHI_ST_ADDR
                              || state_q == chi_pkg::CHI_ST_REG
                              || state_q == chi_pkg::CHI_ST_WDATA)) begin
      shift_q <= {shift_q[6:0], sda_s_q};
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mack_q <= 1'b0;
    end else if (scl_rise && state_q == chi_pkg::CHI_ST_RDATA_ACK) begin
      mack_q <= !sda_s_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rw_q <= 1'b0;
    end else if (scl_fall && state_q == chi_pkg::CHI_ST_ADDR && byte_done) begin
      rw_q <= shift_q[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= 8'h00;
    end else if (scl_fall && state_q == chi_pkg::CHI_ST_REG && byte_done) begin
      ptr_q <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path and data line drive
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_q <= 8'hFF;
    end else if (scl_fall) begin
      if ((state_q == chi_pkg::CHI_ST_ADDR_ACK && rw_q == `CHI_DIR_READ)
          || (state_q == chi_pkg::CHI_ST_RDATA_ACK && mack_q)) begin
        tx_q <= rd_byte;
      end else if (state_q == chi_pkg::CHI_ST_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // The enable changes on the clock's falling edge, and is cleared at a start
  // or stop, so it is never switched on while the clock is high.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      drv_q <= 1'b0;
    end else if (scl_fall) begin
      drv_q <= drv_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drv_q;

  // ----------------------------------------------------------------
  // Speed mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hs_q <= 1'b0;
    end else if (stop_ev) begin
      hs_q <= 1'b0;
    end else if (scl_fall && state_q == chi_pkg::CHI_ST_ADDR && byte_done && mcode) begin
      hs_q <= 1'b1;
    end
  end

  assign hs_mode_o = hs_q;

  // ----------------------------------------------------------------
  // Register write port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_data_o <= 8'h00;
    end else if (scl_fall && state_q == chi_pkg::CHI_ST_WDATA && byte_done) begin
      wr_data_o <= shift_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_en_o <= 1'b0;
      wr_addr_o <= 3'h0;
    end else begin
      wr_en_o <= scl_fall && !start_ev && !stop_ev
                 && state_q == chi_pkg::CHI_ST_WDATA_ACK && reg_writable(ptr_q);
      wr_addr_o <= ptr_q[2:0];
    end
  end

  assign rd_addr_o = ptr_q[2:0];
  assign busy_o = (state_q != chi_pkg::CHI_ST_IDLE);

endmodule

`default_nettype wire

// ===== test/chi_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module chi_bus_master (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Half of the 80 ns link clock, counted on falling system clock edges.
  task automatic half();
    repeat (8) @(negedge ref_clk_i);
  endtask

  // Data moves a little after the clock fall so the slave never sees a false start or stop.
  task automatic clk_bit(input logic b, output logic seen);
    repeat (2) @(negedge ref_clk_i);
    sda_low_o = !b;
    repeat (6) @(negedge ref_clk_i);
    scl_o = 1'b1;
    half();
    seen = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start();
    repeat (2) @(negedge ref_clk_i);
    sda_low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(negedge ref_clk_i);
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], s);
      rx[i] = s;
    end
    clk_bit(!ack_in, s);
    ack = !s;
  endtask
endmodule

`default_nettype wire

// ===== test/chi_slave_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module chi_slave_checker #(
  parameter logic [2:0] RO_REG = 3'h0
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic wr_en_o,
  input wire logic [2:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic [2:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic hs_mode_o,
  input wire logic busy_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence bus_stop;
    scl_i && $rose(sda_i);
  endsequence
  sequence bus_quiet;
    !busy_o && !hs_mode_o;
  endsequence

  AST_SDA_LOW_ONLY: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_WR_PULSE: assert property (wr_en_o |=> !wr_en_o)
    else $error("write strobe longer than one cycle");
  AST_WR_RANGE: assert property (wr_en_o |-> wr_addr_o < 3'h5 && wr_addr_o != RO_REG)
    else $error("write to unmapped or read-only register");
  AST_WR_SCL_LOW: assert property (wr_en_o |-> !scl_i && !$past(scl_i, 2))
    else $error("write not committed after acknowledge clock fall");
  AST_STOP_IDLE: assert property (bus_stop |-> ##[1:8] bus_quiet)
    else $error("stop did not return to idle");
  AST_OE_RISE_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data pulled low while clock high");
  AST_OE_FALL_LOW: assert property ($fell(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("data released during clock high phase");
  AST_IDLE_QUIET: assert property (!busy_o |-> !sda_oe_o && !wr_en_o)
    else $error("activity while bus free");
  AST_HS_NOACK: assert property ($rose(hs_mode_o) |-> !sda_oe_o [*8])
    else $error("master code acknowledged");
endmodule

bind chi_slave chi_slave_checker #(.RO_REG(RO_REG)) i_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .hs_mode_o(hs_mode_o), .busy_o(busy_o));

`default_nettype wire

// ===== test/charger_i2c_slave_interface_test.sv
`timescale 1ns/1ps
`default_nettype none

module charger_i2c_slave_interface_test;
  logic ref_clk, nrst, scl, sda, sda_low, sda_o, sda_oe, wr_en, hs_mode, busy, ack;
  logic [2:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, rx;
  logic [7:0] mem [0:7];
  int n_errors, compares, cycles;

  // Pull-up holds the line high whenever nobody pulls it low.
  assign sda = !(sda_low || (sda_oe && !sda_o));
  // Unmapped reads get 00 here, so the 0xFF must come from the block.
  assign rd_data = (rd_addr < 3'h5) ? mem[rd_addr] : 8'h00;

  chi_slave #(.RO_REG(3'h0)) i_dut (.ref_clk_i(ref_clk), .nrst_i(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .hs_mode_o(hs_mode),
    .busy_o(busy));
  chi_bus_master i_mst (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (wr_en) mem[wr_addr] <= wr_data;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] b, input logic exp);
    i_mst.xfer(b, 1'b0, rx, ack);
    check("ack", {7'h00, ack}, {7'h00, exp});
  endtask

  task automatic rd(input logic [2:0] p, input logic [7:0] exp);
    i_mst.start();
    put(8'hD6, 1'b1);
    put({5'h00, p}, 1'b1);
    i_mst.start();
    put(8'hD7, 1'b1);
    i_mst.xfer(8'hFF, 1'b1, rx, ack);
    check("rd0", rx, exp);
    i_mst.xfer(8'hFF, 1'b0, rx, ack);
    check("rd1", rx, exp);
    i_mst.stop();
  endtask

  task automatic t_write();
    i_mst.start();
    put(8'hD6, 1'b1);
    put(8'h01, 1'b1);
    put(8'hA5, 1'b1);
    put(8'h02, 1'b1);
    put(8'h3C, 1'b1);
    i_mst.stop();
    check("reg1", mem[1], 8'hA5);
    check("reg2", mem[2], 8'h3C);
    check("busy", {7'h00, busy}, 8'h00);
    $display("write test done");
  endtask

  task automatic t_refuse();
    i_mst.start();
    put(8'h50, 1'b0);
    i_mst.start();
    put(8'hD6, 1'b1);
    put(8'h00, 1'b1);
    put(8'hEE, 1'b1);
    put(8'h0D, 1'b1);
    put(8'h99, 1'b1);
    i_mst.stop();
    check("ro", mem[0], 8'hC0);
    check("hi", mem[5], 8'hC5);
    rd(3'h3, 8'hC3);
    rd(3'h6, 8'hFF);
    $display("refuse and read test done");
  endtask

  task automatic t_abort();
    i_mst.start();
    put(8'hD6, 1'b1);
    repeat (3) i_mst.clk_bit(1'b0, ack);
    i_mst.stop();
    check("busy", {7'h00, busy}, 8'h00);
    i_mst.start();
    put(8'hD6, 1'b1);
    put(8'h04, 1'b1);
    put(8'h42, 1'b1);
    i_mst.stop();
    check("reg4", mem[4], 8'h42);
    $display("abort test done");
  endtask

  task automatic t_fast();
    i_mst.start();
    put(8'h0A, 1'b0);
    check("hs", {7'h00, hs_mode}, 8'h01);
    i_mst.start();
    put(8'hD6, 1'b1);
    put(8'h01, 1'b1);
    put(8'h77, 1'b1);
    i_mst.start();
    put(8'hD7, 1'b0);
    i_mst.stop();
    check("hs", {7'h00, hs_mode}, 8'h00);
    check("reg1", mem[1], 8'h77);
    $display("high speed test done");
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    for (int i = 0; i < 8; i++) mem[i] = {5'h18, i[2:0]};
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_write();
    t_refuse();
    t_abort();
    t_fast();
    stop_test();
  end
endmodule

`default_nettype wire
